// ==== rtl/tkcc_top.v ====
// touch key counter control: registers, timing and measurement control
`timescale 1ns/1ps
`include "tkcc_consts.vh"

module tkcc_top (
	// clock and reset
	input  wire        i_ref_clk,
	input  wire        i_arst_n,
	// register port
	input  wire [4:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	// oscillator cycle pulses, one per key module, synchronous
	input  wire [1:0]  i_key_osc_tick,
	input  wire [1:0]  i_ref_osc_tick,
	// oscillator and pin control
	output reg  [1:0]  o_key_osc_run,
	output reg  [1:0]  o_ref_osc_run,
	output reg  [15:0] o_key_pin_sel,
	output reg  [1:0]  o_osc_freq,
	output reg  [19:0] o_ref_cap,
	// interrupt
	output reg         o_irq
);
	// ==========================================================
	// registers
	reg  [7:0]  preload;
	reg         slot_ov;
	reg         start;
	reg         cf_ov;
	reg         func_ov;
	reg         slot_sel;
	reg  [1:0]  func_clk_sel;
	reg  [1:0]  freq_sel;
	reg  [7:0]  mod_ctrl_a [0:1];
	reg  [7:0]  mod_ctrl_b [0:1];
	reg  [7:0]  mod_ctrl_c [0:1];
	reg  [9:0]  mod_ref    [0:1];
	reg  [15:0] func_count;
	reg         start_d;
	reg         running;
	reg         irq_mask;
	reg         irq_flag;
	reg         load_pend;

	wire        div2;
	wire        div4;
	wire        div8;
	wire [15:0] cf_count [0:1];
	wire [1:0]  cf_wrap;
	wire [1:0]  slot_wrap;
	wire [1:0]  slot_tick;
	wire [1:0]  key_tick;

	// ==========================================================
	// helpers
	function [7:0] mod_read;
		input [2:0]  sub;
		input [7:0]  ca;
		input [7:0]  cb;
		input [7:0]  cc;
		input [15:0] cnt;
		input [9:0]  rcap;
		begin
			case (sub)
				`TKCC_SUB_CTRL_A: mod_read = ca;
				`TKCC_SUB_CTRL_B: mod_read = cb;
				`TKCC_SUB_CTRL_C: mod_read = cc;
				`TKCC_SUB_CNT_LO: mod_read = cnt[7:0];
				`TKCC_SUB_CNT_HI: mod_read = cnt[15:8];
				`TKCC_SUB_REF_LO: mod_read = rcap[7:0];
				`TKCC_SUB_REF_HI: mod_read = {6'h00, rcap[9:8]};
				default:          mod_read = 8'h00;
			endcase
		end
	endfunction

	wire       in_m0  = (i_addr >= `TKCC_OFF_M0_BASE) && (i_addr < `TKCC_OFF_M1_BASE);
	wire       in_m1  = (i_addr >= `TKCC_OFF_M1_BASE) && (i_addr < `TKCC_OFF_IRQ_STAT);
	wire [4:0] sub0_w = i_addr - `TKCC_OFF_M0_BASE;
	wire [4:0] sub1_w = i_addr - `TKCC_OFF_M1_BASE;
	wire [2:0] sub0   = sub0_w[2:0];
	wire [2:0] sub1   = sub1_w[2:0];

	// ==========================================================
	// timing sources
	tkcc_divider u_div (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.o_div2    (div2),
		.o_div4    (div4),
		.o_div8    (div8)
	);

	reg func_tick;
	always @* begin
		case (func_clk_sel)
			2'h0:    func_tick = 1'b1;
			2'h1:    func_tick = div2;
			2'h2:    func_tick = div4;
			default: func_tick = div8;
		endcase
	end

	// slot clock per module: reference oscillator needs its enable to run
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_mod
			assign slot_tick[g] = mod_ctrl_b[g][`TKCC_BIT_SLOT_SRC] ?
				div4 : (i_ref_osc_tick[g] && mod_ctrl_b[g][`TKCC_BIT_REF_EN]);
			assign key_tick[g]  = i_key_osc_tick[g] && mod_ctrl_b[g][`TKCC_BIT_KEY_EN];

			tkcc_module #(
				.UNIT_W (5)
			) u_mod (
				.i_ref_clk   (i_ref_clk),
				.i_arst_n    (i_arst_n),
				.i_run       (running),
				.i_clear     (!start),
				.i_load      (load_pend),
				.i_preload   (preload),
				.i_slot_tick (slot_tick[g]),
				.i_key_tick  (key_tick[g]),
				.o_cf_count  (cf_count[g]),
				.o_cf_wrap   (cf_wrap[g]),
				.o_slot_wrap (slot_wrap[g])
			);
		end
	endgenerate

	// shared mode: module zero ends the slot; own mode: every module must be done
	reg  [1:0] done;
	wire       slot_end = running && (slot_sel ? slot_wrap[0] :
		(&(done | slot_wrap)));
	// the count holds in the stop cycle, so no overflow may be flagged there
	wire       func_wrap = running && !slot_end && func_tick && (&func_count);

	// ==========================================================
	// measurement control
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start_d    <= 1'b0;
			running    <= 1'b0;
			func_count <= 16'h0000;
			done       <= 2'h0;
			load_pend  <= 1'b0;
		end else begin
			start_d   <= start;
			load_pend <= start && !start_d;
			if (!start) begin
				running    <= 1'b0;
				func_count <= 16'h0000;
				done       <= 2'h0;
			end else if (start && !start_d) begin
				running <= 1'b1;
				done    <= 2'h0;
			end else if (slot_end) begin
				running <= 1'b0;
			end else if (running) begin
				done <= done | slot_wrap;
				if (func_tick)
					func_count <= func_count + 16'h0001;
			end
		end
	end

	// ==========================================================
	// register writes and flags
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			preload      <= `TKCC_RST_PRELOAD;
			slot_ov      <= 1'b0;
			start        <= 1'b0;
			cf_ov        <= 1'b0;
			func_ov      <= 1'b0;
			slot_sel     <= 1'b0;
			func_clk_sel <= 2'h0;
			freq_sel     <= `TKCC_RST_CTRL_B;
			irq_mask     <= 1'b0;
			irq_flag     <= 1'b0;
			mod_ctrl_a[0] <= `TKCC_RST_MOD;
			mod_ctrl_a[1] <= `TKCC_RST_MOD;
			mod_ctrl_b[0] <= `TKCC_RST_MOD;
			mod_ctrl_b[1] <= `TKCC_RST_MOD;
			mod_ctrl_c[0] <= `TKCC_RST_MOD;
			mod_ctrl_c[1] <= `TKCC_RST_MOD;
			mod_ref[0]    <= 10'h000;
			mod_ref[1]    <= 10'h000;
		end else begin
			if (i_wr) begin
				case (i_addr)
					`TKCC_OFF_PRELOAD: preload <= i_wdata;
					`TKCC_OFF_CTRL_A: begin
						// flags: software may clear, never set
						if (!i_wdata[`TKCC_BIT_SLOT_OV])
							slot_ov <= 1'b0;
						if (!i_wdata[`TKCC_BIT_CF_OV])
							cf_ov <= 1'b0;
						if (!i_wdata[`TKCC_BIT_FUNC_OV])
							func_ov <= 1'b0;
						start        <= i_wdata[`TKCC_BIT_START];
						slot_sel     <= i_wdata[`TKCC_BIT_SLOT_SEL];
						func_clk_sel <= {i_wdata[1], func_clk_sel[0]};
					end
					`TKCC_OFF_CTRL_B: freq_sel <= i_wdata[1:0];
					`TKCC_OFF_IRQ_STAT: begin
						if (i_wdata[0])
							irq_flag <= 1'b0;
					end
					`TKCC_OFF_IRQ_MASK: irq_mask <= i_wdata[0];
					default: begin
						if (in_m0) begin
							case (sub0)
								`TKCC_SUB_CTRL_A: mod_ctrl_a[0] <= i_wdata;
								`TKCC_SUB_CTRL_B: mod_ctrl_b[0] <= i_wdata;
								`TKCC_SUB_CTRL_C: mod_ctrl_c[0] <= i_wdata;
								`TKCC_SUB_REF_LO: mod_ref[0][7:0] <= i_wdata;
								`TKCC_SUB_REF_HI: mod_ref[0][9:8] <= i_wdata[1:0];
								default: ;
							endcase
						end
						if (in_m1) begin
							case (sub1)
								`TKCC_SUB_CTRL_A: mod_ctrl_a[1] <= i_wdata;
								`TKCC_SUB_CTRL_B: mod_ctrl_b[1] <= i_wdata;
								`TKCC_SUB_CTRL_C: mod_ctrl_c[1] <= i_wdata;
								`TKCC_SUB_REF_LO: mod_ref[1][7:0] <= i_wdata;
								`TKCC_SUB_REF_HI: mod_ref[1][9:8] <= i_wdata[1:0];
								default: ;
							endcase
						end
					end
				endcase
			end
			// hardware set wins over a same-cycle clear
			if (slot_end) begin
				slot_ov  <= 1'b1;
				irq_flag <= 1'b1;
			end
			if (|cf_wrap && running)
				cf_ov <= 1'b1;
			if (func_wrap)
				func_ov <= 1'b1;
		end
	end

	// ==========================================================
	// read port and outputs
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata       <= 8'h00;
			o_key_osc_run <= 2'h0;
			o_ref_osc_run <= 2'h0;
			o_key_pin_sel <= 16'h0000;
			o_osc_freq    <= `TKCC_RST_CTRL_B;
			o_ref_cap     <= 20'h00000;
			o_irq         <= 1'b0;
		end else begin
			o_rdata <= 8'h00;
			if (i_rd) begin
				case (i_addr)
					`TKCC_OFF_PRELOAD:  o_rdata <= preload;
					`TKCC_OFF_CTRL_A:   o_rdata <= {1'b0, slot_ov, start, cf_ov,
						func_ov, slot_sel, func_clk_sel};
					`TKCC_OFF_CTRL_B:   o_rdata <= {6'h00, freq_sel};
					`TKCC_OFF_FCNT_LO:  o_rdata <= func_count[7:0];
					`TKCC_OFF_FCNT_HI:  o_rdata <= func_count[15:8];
					`TKCC_OFF_IRQ_STAT: o_rdata <= {7'h00, irq_flag};
					`TKCC_OFF_IRQ_MASK: o_rdata <= {7'h00, irq_mask};
					default: begin
						if (in_m0)
							o_rdata <= mod_read(sub0, mod_ctrl_a[0], mod_ctrl_b[0],
								mod_ctrl_c[0], cf_count[0], mod_ref[0]);
						else if (in_m1)
							o_rdata <= mod_read(sub1, mod_ctrl_a[1], mod_ctrl_b[1],
								mod_ctrl_c[1], cf_count[1], mod_ref[1]);
					end
				endcase
			end
			// oscillators stop at slot end and only run when enabled
			o_key_osc_run <= {2{running && !slot_end}} &
				{mod_ctrl_b[1][`TKCC_BIT_KEY_EN], mod_ctrl_b[0][`TKCC_BIT_KEY_EN]};
			o_ref_osc_run <= {2{running && !slot_end}} &
				{mod_ctrl_b[1][`TKCC_BIT_REF_EN], mod_ctrl_b[0][`TKCC_BIT_REF_EN]};
			o_key_pin_sel <= {mod_ctrl_c[1][3:0], mod_ctrl_b[1][3:0],
				mod_ctrl_c[0][3:0], mod_ctrl_b[0][3:0]};
			o_osc_freq    <= freq_sel;
			o_ref_cap     <= {mod_ref[1], mod_ref[0]};
			o_irq         <= irq_flag && irq_mask;
		end
	end
endmodule

// ==== rtl/tkcc_consts.vh ====
// constants for the touch key counter control block
`ifndef TKCC_CONSTS_VH
`define TKCC_CONSTS_VH

// ==========================================================
// register offsets (byte index on the plain register port)
`define TKCC_OFF_PRELOAD     5'h00
`define TKCC_OFF_CTRL_A      5'h01
`define TKCC_OFF_CTRL_B      5'h02
`define TKCC_OFF_FCNT_LO     5'h03
`define TKCC_OFF_FCNT_HI     5'h04
`define TKCC_OFF_M0_BASE     5'h05
`define TKCC_OFF_M1_BASE     5'h0c
`define TKCC_OFF_IRQ_STAT    5'h13
`define TKCC_OFF_IRQ_MASK    5'h14
// per-module sub offsets from the module base
`define TKCC_SUB_CTRL_A      3'h0
`define TKCC_SUB_CTRL_B      3'h1
`define TKCC_SUB_CTRL_C      3'h2
`define TKCC_SUB_CNT_LO      3'h3
`define TKCC_SUB_CNT_HI      3'h4
`define TKCC_SUB_REF_LO      3'h5
`define TKCC_SUB_REF_HI      3'h6

// ==========================================================
// control register a field positions
`define TKCC_BIT_SLOT_OV     6
`define TKCC_BIT_START       5
`define TKCC_BIT_CF_OV       4
`define TKCC_BIT_FUNC_OV     3
`define TKCC_BIT_SLOT_SEL    2
// module control b field positions
`define TKCC_BIT_SLOT_SRC    7
`define TKCC_BIT_REF_EN      5
`define TKCC_BIT_KEY_EN      4

// ==========================================================
// reset values
`define TKCC_RST_PRELOAD     8'h00
`define TKCC_RST_CTRL_B      2'h3
`define TKCC_RST_MOD         8'h00

// ==========================================================
// timing counts
`define TKCC_UNIT_PERIOD     32
`define TKCC_SLOT_SYS_DIV    4

`endif

// ==== rtl/tkcc_divider.v ====
// system clock divider producing one-cycle enable pulses
`timescale 1ns/1ps

module tkcc_divider (
	// clock and reset
	input  wire       i_ref_clk,
	input  wire       i_arst_n,
	// enable pulses
	output wire       o_div2,
	output wire       o_div4,
	output wire       o_div8
);
	reg [2:0] count;

	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count <= 3'h0;
		end else begin
			count <= count + 3'h1;
		end
	end

	assign o_div2 = count[0];
	assign o_div4 = (count[1:0] == 2'h3);
	assign o_div8 = (count == 3'h7);
endmodule

// ==== rtl/tkcc_module.v ====
// one touch module: key counter, unit period and slot counters
`timescale 1ns/1ps
`include "tkcc_consts.vh"

module tkcc_module #(
	parameter UNIT_W = 5
) (
	// clock and reset
	input  wire        i_ref_clk,
	input  wire        i_arst_n,
	// control
	input  wire        i_run,
	input  wire        i_clear,
	input  wire        i_load,
	input  wire [7:0]  i_preload,
	input  wire        i_slot_tick,
	input  wire        i_key_tick,
	// status
	output reg  [15:0] o_cf_count,
	output wire        o_cf_wrap,
	output wire        o_slot_wrap
);
	reg [UNIT_W-1:0] unit;
	reg [7:0]        slot;

	wire unit_end = i_run && i_slot_tick && (&unit);
	assign o_slot_wrap = unit_end && (&slot);
	assign o_cf_wrap   = i_run && i_key_tick && (&o_cf_count);

	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cf_count <= 16'h0000;
			unit       <= {UNIT_W{1'b0}};
			slot       <= 8'h00;
		end else begin
			if (i_clear) begin
				o_cf_count <= 16'h0000;
				unit       <= {UNIT_W{1'b0}};
			end else if (i_run) begin
				if (i_key_tick)
					o_cf_count <= o_cf_count + 16'h0001;
				if (i_slot_tick)
					unit <= unit + {{(UNIT_W-1){1'b0}}, 1'b1};
			end
			// slot counter keeps its value while stopped; reloaded at start
			if (i_load)
				slot <= i_preload;
			else if (unit_end)
				slot <= slot + 8'h01;
		end
	end
endmodule

// ==== tb/tkcc_monitor.sv ====
// port assertions for the touch key counter control block
`timescale 1ns/1ps
module tkcc_monitor (
	// clock and reset
	input wire        i_ref_clk,
	input wire        i_arst_n,
	// register port
	input wire [4:0]  i_addr,
	input wire [7:0]  i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [7:0]  o_rdata,
	// outputs
	input wire [1:0]  o_key_osc_run,
	input wire [1:0]  o_ref_osc_run,
	input wire [15:0] o_key_pin_sel,
	input wire [1:0]  o_osc_freq,
	input wire        o_irq
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);
	// ==========================================================
	// read port
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_ctrl_unimpl: assert property ($past(i_rd) && $past(i_addr) == 5'h01
		|-> o_rdata[7] == 1'b0 && o_rdata[0] == 1'b0) else $error("control a spare bits");
	a_freq_unimpl: assert property ($past(i_rd) && $past(i_addr) == 5'h02
		|-> o_rdata[7:2] == 6'h00) else $error("control b spare bits");
	a_refhi_unimpl: assert property ($past(i_rd) && ($past(i_addr) == 5'h0b
		|| $past(i_addr) == 5'h12) |-> o_rdata[7:2] == 6'h00) else $error("refcap high bits");
	a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 5'h14
		|-> o_rdata == 8'h00) else $error("unmapped read not zero");
	// ==========================================================
	// control outputs follow their registers
	a_freq_follow: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_wr && i_addr == 5'h02 ##1 !(i_wr && i_addr == 5'h02)
		|=> {6'h00, o_osc_freq} == ($past(i_wdata, 2) & 8'h03))
		else $error("frequency output stale");
	a_pinsel_follow: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_wr && i_addr == 5'h06 ##1 !(i_wr && i_addr == 5'h06)
		|=> {4'h0, o_key_pin_sel[3:0]} == ($past(i_wdata, 2) & 8'h0f))
		else $error("key pin select stale");
	a_irq_masked: assert property (i_wr && i_addr == 5'h14 && !i_wdata[0]
		##1 !(i_wr && i_addr == 5'h14) |=> !o_irq) else $error("masked interrupt seen");
	a_run_stop: assert property (i_wr && i_addr == 5'h01 && !i_wdata[5]
		|-> ##[1:3] (o_key_osc_run == 2'b00 && o_ref_osc_run == 2'b00))
		else $error("oscillators run after stop");
endmodule

bind tkcc_top tkcc_monitor i_tkcc_monitor (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_key_osc_run(o_key_osc_run),
	.o_ref_osc_run(o_ref_osc_run), .o_key_pin_sel(o_key_pin_sel),
	.o_osc_freq(o_osc_freq), .o_irq(o_irq));

// ==== tb/tkcc_pads.sv ====
// touch pad and reference oscillator model for both key modules
`timescale 1ns/1ps
module tkcc_pads (
	// clock
	input  wire       i_ref_clk,
	// oscillator run levels from the block
	input  wire [1:0] i_key_run,
	input  wire [1:0] i_ref_run,
	// periods in clock cycles, at least 1
	input  wire [7:0] i_key_per,
	input  wire [7:0] i_ref_per,
	// oscillator cycle pulses
	output reg  [1:0] o_key_tick,
	output reg  [1:0] o_ref_tick
);
	reg [7:0] kc [0:1];
	reg [7:0] rc [0:1];
	integer   m;
	// a stopped oscillator gives no edges and restarts its phase
	always @(posedge i_ref_clk) begin
		for (m = 0; m < 2; m = m + 1) begin
			kc[m] <= (!i_key_run[m] || kc[m] + 8'h01 >= i_key_per) ? 8'h00 : kc[m] + 8'h01;
			rc[m] <= (!i_ref_run[m] || rc[m] + 8'h01 >= i_ref_per) ? 8'h00 : rc[m] + 8'h01;
			o_key_tick[m] <= i_key_run[m] && kc[m] + 8'h01 >= i_key_per;
			o_ref_tick[m] <= i_ref_run[m] && rc[m] + 8'h01 >= i_ref_per;
		end
	end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the touch key counter control block
`timescale 1ns/1ps
`include "tkcc_consts.vh"
module tb_top;
	reg         i_ref_clk;
	reg         i_arst_n;
	reg  [4:0]  i_addr;
	reg  [7:0]  i_wdata;
	reg         i_wr;
	reg         i_rd;
	wire [7:0]  o_rdata;
	wire [1:0]  key_tick;
	wire [1:0]  ref_tick;
	wire [1:0]  o_key_osc_run;
	wire [1:0]  o_ref_osc_run;
	wire [15:0] o_key_pin_sel;
	wire [1:0]  o_osc_freq;
	wire [19:0] o_ref_cap;
	wire        o_irq;
	reg  [7:0]  key_per;
	reg  [7:0]  ref_per;
	reg  [7:0]  d;
	reg  [7:0]  r;
	reg  [15:0] w;
	integer     errors;
	integer     checks;
	integer     seed;
	integer     i;
	integer     n;
	integer     e;

	tkcc_top i_tkcc_top (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_key_osc_tick(key_tick), .i_ref_osc_tick(ref_tick),
		.o_key_osc_run(o_key_osc_run), .o_ref_osc_run(o_ref_osc_run),
		.o_key_pin_sel(o_key_pin_sel), .o_osc_freq(o_osc_freq), .o_ref_cap(o_ref_cap),
		.o_irq(o_irq));
	tkcc_pads i_tkcc_pads (.i_ref_clk(i_ref_clk), .i_key_run(o_key_osc_run),
		.i_ref_run(o_ref_osc_run), .i_key_per(key_per), .i_ref_per(ref_per),
		.o_key_tick(key_tick), .o_ref_tick(ref_tick));

	// ==========================================================
	// checking and bus tasks
	task results;
		begin
			if (errors == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [8*16-1:0] nm, input [15:0] x, input [15:0] s);
		begin
			checks = checks + 1;
			if (s !== x) begin
				errors = errors + 1;
				$display("unexpected %0s: expected %h, seen %h", nm, x, s);
			end
		end
	endtask
	// pad phase and divider phase make counts land within a few units
	task near(input [8*16-1:0] nm, input integer x, input integer s, input integer t);
		chk(nm, (s >= x - t && s <= x + t) ? s[15:0] : x[15:0], s[15:0]);
	endtask
	function integer slot_len(input [7:0] pre, input integer per);
		slot_len = (256 - pre) * 32 * per;
	endfunction
	task wr(input [4:0] a, input [7:0] v);
		begin
			@(posedge i_ref_clk);
			i_addr <= a;
			i_wdata <= v;
			i_wr <= 1'b1;
			@(posedge i_ref_clk);
			i_wr <= 1'b0;
		end
	endtask
	task rd(input [4:0] a, output [7:0] v);
		begin
			@(posedge i_ref_clk);
			i_addr <= a;
			i_rd <= 1'b1;
			@(posedge i_ref_clk);
			i_rd <= 1'b0;
			#1 v = o_rdata;
		end
	endtask
	task rchk(input [4:0] a, input [7:0] x);
		begin
			rd(a, r);
			chk("register", {8'h00, x}, {8'h00, r});
		end
	endtask

	// ==========================================================
	// one measurement: fs is {slot select, function clock}, slot clock period per
	task meas(input [7:0] pre, input [2:0] fs, input [7:0] mb, input integer per,
		input [1:0] flg);
		begin
			e = slot_len(pre, per);
			wr(`TKCC_OFF_PRELOAD, pre);
			wr(`TKCC_OFF_M0_BASE + 5'h01, mb);
			wr(`TKCC_OFF_M1_BASE + 5'h01, mb);
			wr(`TKCC_OFF_IRQ_MASK, 8'h01);
			wr(`TKCC_OFF_CTRL_A, {5'b00000, fs});
			wr(`TKCC_OFF_CTRL_A, {5'b00100, fs});
			repeat (3) @(posedge i_ref_clk);
			#1 chk("osc run", {12'h000, {2{mb[5]}}, {2{mb[4]}}},
				{12'h000, o_ref_osc_run, o_key_osc_run});
			n = 3;
			while (o_irq !== 1'b1 && n < e + 64) begin
				@(posedge i_ref_clk);
				#1;
				n = n + 1;
			end
			if (n >= e + 64) begin
				errors = errors + 1;
				results;
			end
			near("slot length", e, n, 8);
			rchk(`TKCC_OFF_CTRL_A, {3'b011, flg, fs[2], fs[1], 1'b0});
			rd(`TKCC_OFF_FCNT_LO, w[7:0]);
			rd(`TKCC_OFF_FCNT_HI, w[15:8]);
			if (flg == 2'b00) begin
				near("function count", e >> (fs[1] * 2), w, 4);
				rd(`TKCC_OFF_M0_BASE + 5'h03, d);
				rd(`TKCC_OFF_M0_BASE + 5'h04, r);
				near("key count", e / key_per, {r, d}, 4);
			end
			repeat (20) @(posedge i_ref_clk);
			rchk(`TKCC_OFF_FCNT_LO, w[7:0]);
			chk("oscillators", 16'h0000, {14'h0, o_key_osc_run | o_ref_osc_run});
			wr(`TKCC_OFF_IRQ_MASK, 8'h00);
			rchk(`TKCC_OFF_IRQ_STAT, 8'h01);
			chk("irq", 16'h0000, {15'h0, o_irq});
			wr(`TKCC_OFF_IRQ_STAT, 8'h01);
			wr(`TKCC_OFF_CTRL_A, {5'b00000, fs});
			rchk(`TKCC_OFF_IRQ_STAT, 8'h00);
			rchk(`TKCC_OFF_CTRL_A, {5'b00000, fs[2], fs[1], 1'b0});
			rchk(`TKCC_OFF_FCNT_LO, 8'h00);
			rchk(`TKCC_OFF_M1_BASE + 5'h03, 8'h00);
		end
	endtask

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	initial begin
		i_arst_n = 1'b0;
		i_addr = 5'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		key_per = 8'h03;
		ref_per = 8'h02;
		errors = 0;
		checks = 0;
		seed = 32'h5795e542;
		repeat (20) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		chk("freq out", 16'h0003, {14'h0, o_osc_freq});
		rchk(`TKCC_OFF_CTRL_B, 8'h03);
		rchk(`TKCC_OFF_CTRL_A, 8'h00);
		rchk(`TKCC_OFF_FCNT_HI, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			d = $random(seed);
			wr(`TKCC_OFF_PRELOAD, d);
			rchk(`TKCC_OFF_PRELOAD, d);
			wr(`TKCC_OFF_M0_BASE + 5'h06, d);
			rchk(`TKCC_OFF_M0_BASE + 5'h06, d & 8'h03);
			wr(`TKCC_OFF_M1_BASE + 5'h05, d);
			@(posedge i_ref_clk);
			#1;
			chk("refcap", {8'h00, d}, {8'h00, o_ref_cap[17:10]});
			wr(`TKCC_OFF_CTRL_B, d);
			rchk(`TKCC_OFF_CTRL_B, d & 8'h03);
		end
		wr(`TKCC_OFF_FCNT_LO, 8'hff);
		rchk(`TKCC_OFF_FCNT_LO, 8'h00);
		rchk(5'h1f, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`TKCC_OFF_CTRL_A, i[7:0]);
			rchk(`TKCC_OFF_CTRL_A, {6'h00, i[1], 1'b0});
		end
		// software cannot raise any flag
		wr(`TKCC_OFF_CTRL_A, 8'h58);
		rchk(`TKCC_OFF_CTRL_A, 8'h00);
		rchk(`TKCC_OFF_IRQ_STAT, 8'h00);
		meas(8'hfe, 3'b110, 8'hb0 | d[3:0], 4, 2'b00);
		meas(8'hfd, 3'b000, 8'hbf, 4, 2'b00);
		// long slot from the reference pads overruns both 16-bit counters
		key_per = 8'h01;
		ref_per = 8'h09;
		meas(8'h00, 3'b100, 8'h30, 9, 2'b11);
		results;
	end
endmodule
